// ---- nested_priority_irq_gate.sv ----
// Priority and threshold gate for nested interrupts toward the core
// Notes on behaviour
// - Every source holds a priority of 1, 2 or 3; larger is more urgent.
// - Software sets each source's priority individually; a source never set runs at the lowest level, 1.
// - A pending request goes to the core only if its priority exceeds the threshold.
// - Higher priority preempts a running lower handler; the lower one resumes afterwards.
// - After reset nesting is on and the threshold is zero.
// - Threshold one during flash work still lets priorities two and three through.
`timescale 1ns/1ps
module nested_priority_irq_gate (
    input  wire logic                                                clk_sys_i,
    input  wire logic                                                rstn_i,
    input  wire logic [nested_priority_irq_gate_pkg::NUM_SRC-1:0]    irq_src_i,
    input  wire logic                                                cfg_pri_we_i,
    input  wire logic [nested_priority_irq_gate_pkg::SRC_W-1:0]      cfg_src_i,
    input  wire logic [nested_priority_irq_gate_pkg::PRI_W-1:0]      cfg_pri_i,
    input  wire logic                                                thr_we_i,
    input  wire logic [nested_priority_irq_gate_pkg::PRI_W-1:0]      thr_i,
    input  wire logic                                                nest_we_i,
    input  wire logic                                                nest_en_i,
    input  wire logic                                                claim_i,
    input  wire logic                                                complete_i,
    output logic                                                     irq_req_o,
    output logic      [nested_priority_irq_gate_pkg::SRC_W-1:0]      irq_id_o,
    output logic      [nested_priority_irq_gate_pkg::PRI_W-1:0]      irq_pri_o,
    output logic      [nested_priority_irq_gate_pkg::PRI_W-1:0]      thr_o,
    output logic                                                     nest_en_o,
    output logic      [nested_priority_irq_gate_pkg::DEPTH_W-1:0]    depth_o,
    output logic      [nested_priority_irq_gate_pkg::PRI_W-1:0]      active_pri_o
);
    import nested_priority_irq_gate_pkg::*;

    typedef struct packed {
        logic [NUM_SRC-1:0]                sync1;    // First synchroniser stage
        logic [NUM_SRC-1:0]                sync2;    // Second synchroniser stage
        logic [NUM_SRC-1:0]                prev;     // Edge detector history
        logic [NUM_SRC-1:0]                pend;     // Sticky pending requests
        logic [NUM_SRC-1:0][PRI_W-1:0]     pri;      // Priority per source
        logic [PRI_W-1:0]                  thr;      // Current threshold
        logic                              nest_en;  // Nesting allowed
        logic [STACK_DEPTH-1:0][SRC_W-1:0] stk_id;   // Handlers in service
        logic [STACK_DEPTH-1:0][PRI_W-1:0] stk_pri;  // Their priorities
        logic [DEPTH_W-1:0]                depth;    // Handlers in service
        logic                              req;      // Request to the core
        logic [SRC_W-1:0]                  id;       // Offered source
        logic [PRI_W-1:0]                  req_pri;  // Offered priority
        logic [PRI_W-1:0]                  act_pri;  // Level in service, kept in a flop for the pin
        logic                              started;  // Low only in first cycle
    } gate_s;

    gate_s st;
    gate_s next_st;

    arb_if             arb ();
    logic [NUM_SRC-1:0] rise;
    logic               claim_ok;
    logic [DEPTH_W-1:0] d;
    logic [PRI_W-1:0]   running;
    logic [PRI_W-1:0]   next_running;

    ////////////////////////////////////////////////////////////////////////////
    // Priority of the handler on top of the nesting stack, none when idle
    function automatic logic [PRI_W-1:0] top_pri(
        input logic [STACK_DEPTH-1:0][PRI_W-1:0] stk,
        input logic [DEPTH_W-1:0]                dep
    );
        logic [PRI_W-1:0] r;
        r = pri_none;
        if (dep != '0) begin
            r = stk[dep - 2'h1];
        end
        return r;
    endfunction : top_pri

    nested_priority_arbiter u_arbiter (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .bus       (arb.arb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state. Arbitration looks at the next state so that the registered
    // offer always agrees with the registered threshold, stack and pending set.
    always_comb begin
        next_st       = st;
        next_st.started = 1'b1;
        next_st.sync1 = irq_src_i;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        rise          = st.sync2 & ~st.prev;
        claim_ok      = claim_i && st.req;
        // Pending: a new edge wins over a claim in the same cycle
        if (claim_ok) begin
            next_st.pend[st.id] = 1'b0;
        end
        next_st.pend = next_st.pend | rise;
        // Zero is not a legal level, so it is stored as the lowest one
        if (cfg_pri_we_i) begin
            next_st.pri[cfg_src_i] = (cfg_pri_i == pri_none) ? priority_normal_app
                                                             : cfg_pri_i;
        end
        if (thr_we_i) begin
            next_st.thr = thr_i;
        end
        if (nest_we_i) begin
            next_st.nest_en = nest_en_i;
        end
        // Return pops first, so a claim in the same cycle replaces the top
        d = st.depth;
        if (complete_i && (d != '0)) begin
            d = d - 2'h1;
        end
        if (claim_ok && (32'(d) < STACK_DEPTH)) begin
            next_st.stk_id[d]  = st.id;
            next_st.stk_pri[d] = st.req_pri;
            d = d + 2'h1;
        end
        next_st.depth = d;
        next_running  = top_pri(next_st.stk_pri, next_st.depth);
        next_st.act_pri = next_running;
        // Floor: threshold, or the running level if higher; urgent level while a handler runs with nesting off
        arb.pending = next_st.pend;
        arb.pri     = next_st.pri;
        if (next_st.depth != '0 && !next_st.nest_en) begin
            arb.floor = priority_urgent_app;
        end else if (next_running > next_st.thr) begin
            arb.floor = next_running;
        end else begin
            arb.floor = next_st.thr;
        end
        next_st.req     = arb.valid;
        next_st.id      = arb.id;
        next_st.req_pri = arb.best_pri;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; priorities start at the lowest level
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st         <= '0;
            st.pri     <= {NUM_SRC{pri_reset}};
            st.thr     <= thr_reset;
            st.nest_en <= nest_reset;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state
    assign running      = st.act_pri;
    assign irq_req_o    = st.req;
    assign irq_id_o     = st.id;
    assign irq_pri_o    = st.req_pri;
    assign thr_o        = st.thr;
    assign nest_en_o    = st.nest_en;
    assign depth_o      = st.depth;
    assign active_pri_o = running;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence nested_return_s;
        complete_i && !claim_i && (st.depth == 2'h2);
    endsequence

    sequence radio_waiting_s;
        (st.thr == thr_flash) && (st.depth == '0)
            && st.pend[radio_interrupt_src]
            && (st.pri[radio_interrupt_src] >= priority_radio_stack);
    endsequence

    pri_legal_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        st.req |-> (st.req_pri != pri_none) && (st.req_pri == st.pri[st.id]))
        else $error("Offered priority is zero or stale");

    cfg_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (cfg_pri_we_i && cfg_pri_i != pri_none)
            |=> st.pri[$past(cfg_src_i)] == $past(cfg_pri_i))
        else $error("Priority write not stored");

    thr_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        st.req |-> st.req_pri > st.thr)
        else $error("Request offered at or below threshold");

    preempt_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (st.req && st.depth != '0) |-> (st.req_pri > running) && st.nest_en)
        else $error("Offer does not outrank running handler");

    resume_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        nested_return_s |=> (st.depth == 2'h1) && (running == $past(st.stk_pri[0])))
        else $error("Interrupted handler not resumed");

    reset_state_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !st.started |-> (st.thr == thr_reset) && st.nest_en && (st.depth == '0))
        else $error("Wrong state after reset");

    flash_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        radio_waiting_s |-> st.req && (st.req_pri >= priority_radio_stack))
        else $error("Priority two blocked by flash threshold");

    claim_push_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (claim_i && st.req && !complete_i)
            |=> (st.depth == $past(st.depth) + 2'h1) && (running == $past(st.req_pri)))
        else $error("Claimed handler not placed in service");

endmodule : nested_priority_irq_gate

// ---- nested_priority_irq_gate_pkg.sv ----
// Constants shared by the nested interrupt priority gate and its arbiter
package nested_priority_irq_gate_pkg;

    localparam int unsigned NUM_SRC     = 8;    // Interrupt sources handled
    localparam int unsigned SRC_W       = 3;    // Width of a source number
    localparam int unsigned PRI_W       = 2;    // Width of a priority or threshold
    localparam int unsigned STACK_DEPTH = 3;    // One nesting slot per priority level
    localparam int unsigned DEPTH_W     = 2;    // Width of the nesting depth count

    // Priority levels; a larger value is more urgent
    localparam logic [PRI_W-1:0] pri_none             = 2'h0;
    localparam logic [PRI_W-1:0] priority_normal_app  = 2'h1;
    localparam logic [PRI_W-1:0] priority_radio_stack = 2'h2;
    localparam logic [PRI_W-1:0] priority_urgent_app  = 2'h3;

    // Reset values
    localparam logic [PRI_W-1:0] thr_reset  = 2'h0;
    localparam logic             nest_reset = 1'b1;
    localparam logic [PRI_W-1:0] pri_reset  = priority_normal_app;

    // Source wired to the radio interrupt
    localparam logic [SRC_W-1:0] radio_interrupt_src = 3'h0;

    // Threshold held during flash erase, read or write
    localparam logic [PRI_W-1:0] thr_flash = 2'h1;

endpackage : nested_priority_irq_gate_pkg

// ---- arb_if.sv ----
// Carrier between the gate and its priority arbiter
`timescale 1ns/1ps
interface arb_if;
    import nested_priority_irq_gate_pkg::*;

    logic [NUM_SRC-1:0]            pending;   // Pending requests
    logic [NUM_SRC-1:0][PRI_W-1:0] pri;       // Priority per source
    logic [PRI_W-1:0]              floor;     // A request must be above this
    logic                          valid;     // A request is eligible
    logic [SRC_W-1:0]              id;        // Winning source
    logic [PRI_W-1:0]              best_pri;  // Priority of the winner

    modport gate (output pending, output pri, output floor,
                  input valid, input id, input best_pri);
    modport arb  (input pending, input pri, input floor,
                  output valid, output id, output best_pri);
endinterface : arb_if

// ---- nested_priority_arbiter.sv ----
// Picks the most urgent eligible source, lowest number first on a tie
`timescale 1ns/1ps
module nested_priority_arbiter (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    arb_if.arb        bus
);
    import nested_priority_irq_gate_pkg::*;

    logic [NUM_SRC-1:0] elig;
    logic               lower_tie;
    logic               higher_left;

    ////////////////////////////////////////////////////////////////////////////
    // Eligibility: pending and strictly above the floor
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_elig
            assign elig[i] = bus.pending[i] && (bus.pri[i] > bus.floor);
        end
    endgenerate

    // Scan downward so a lower number overwrites an equal priority
    always_comb begin
        bus.valid    = 1'b0;
        bus.id       = '0;
        bus.best_pri = pri_none;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i] && (bus.pri[i] >= bus.best_pri)) begin
                bus.valid    = 1'b1;
                bus.id       = SRC_W'(i);
                bus.best_pri = bus.pri[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers: any better candidate left behind
    always_comb begin
        lower_tie   = 1'b0;
        higher_left = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (elig[i] && (SRC_W'(i) < bus.id) && (bus.pri[i] == bus.best_pri)) begin
                lower_tie = 1'b1;
            end
            if (elig[i] && (bus.pri[i] > bus.best_pri)) begin
                higher_left = 1'b1;
            end
        end
    end

    tie_order_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        bus.valid |-> !lower_tie && !higher_left)
        else $error("Arbiter skipped a better or lower-numbered source");

    above_floor_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        bus.valid |-> (bus.best_pri > bus.floor) && bus.pending[bus.id])
        else $error("Arbiter picked a source not above the floor");

endmodule : nested_priority_arbiter

// ---- core_model.sv ----
// Processor core stand-in that claims offered requests and returns from handlers
`timescale 1ns/1ps
module core_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       irq_req_i,
    input  wire logic       auto_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       ret_i,
    output logic            claim_o,
    output logic            complete_o
);
    logic [3:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // Claim only after the offer has stood delay_i cycles, so slow cores are tried too
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_cnt   <= 4'h0;
            claim_o    <= 1'b0;
            complete_o <= 1'b0;
        end else begin
            claim_o    <= 1'b0;
            complete_o <= ret_i;            // Return from the top handler
            if (auto_i && irq_req_i && !claim_o) begin
                if (wait_cnt >= delay_i) begin
                    claim_o  <= 1'b1;       // Take the offer
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else if (!irq_req_i) begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : core_model

// ---- nested_priority_irq_gate_tb_top.sv ----
// Self-checking bench for the nested interrupt priority gate
`timescale 1ns/1ps
module nested_priority_irq_gate_tb_top;
    import nested_priority_irq_gate_pkg::*;
    logic               clk_sys_i = 1'b0;
    logic               rstn_i = 1'b0;
    logic [NUM_SRC-1:0] irq_src_i = '0;
    logic               cfg_pri_we_i = 1'b0;
    logic [SRC_W-1:0]   cfg_src_i = '0;
    logic [PRI_W-1:0]   cfg_pri_i = '0;
    logic               thr_we_i = 1'b0;
    logic [PRI_W-1:0]   thr_i = '0;
    logic               nest_we_i = 1'b0;
    logic               nest_en_i = 1'b1;
    logic               claim_i, complete_i, irq_req_o, nest_en_o;
    logic [SRC_W-1:0]   irq_id_o;
    logic [PRI_W-1:0]   irq_pri_o, thr_o, active_pri_o;
    logic [DEPTH_W-1:0] depth_o;
    logic               auto = 1'b0;
    logic               ret = 1'b0;
    logic [3:0]         dly = 4'h1;
    int                 miscompares = 0;
    int                 checked = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    nested_priority_irq_gate nested_priority_irq_gate_inst (.clk_sys_i, .rstn_i, .irq_src_i,
        .cfg_pri_we_i, .cfg_src_i, .cfg_pri_i, .thr_we_i, .thr_i, .nest_we_i, .nest_en_i,
        .claim_i, .complete_i, .irq_req_o, .irq_id_o, .irq_pri_o, .thr_o, .nest_en_o,
        .depth_o, .active_pri_o);
    core_model core_model_inst (.clk_sys_i, .rstn_i, .irq_req_i(irq_req_o), .auto_i(auto),
        .delay_i(dly), .ret_i(ret), .claim_o(claim_i), .complete_o(complete_i));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic set_pri(input logic [2:0] s, input logic [1:0] p);
        @(posedge clk_sys_i);
        cfg_pri_we_i <= 1'b1;
        cfg_src_i    <= s;
        cfg_pri_i    <= p;
        @(posedge clk_sys_i);
        cfg_pri_we_i <= 1'b0;
    endtask : set_pri

    task automatic set_thr(input logic [1:0] t);
        @(posedge clk_sys_i);
        thr_we_i <= 1'b1;
        thr_i    <= t;
        @(posedge clk_sys_i);
        thr_we_i <= 1'b0;
        #1;
        chk("thr", 4'(t), 4'(thr_o));
    endtask : set_thr

    // Edges are held two cycles so the input synchroniser cannot miss them
    task automatic raise(input logic [NUM_SRC-1:0] m);
        @(posedge clk_sys_i);
        irq_src_i <= irq_src_i | m;
        repeat (2) @(posedge clk_sys_i);
        irq_src_i <= irq_src_i & ~m;
    endtask : raise

    task automatic offer(input logic [2:0] id, input logic [1:0] p);
        int n;
        n = 0;
        #1;
        while (irq_req_o !== 1'b1 && n < 12) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        // Out of patience: count it and go straight to the verdict
        if (irq_req_o !== 1'b1) begin
            chk("offer", 4'h1, 4'(irq_req_o));
            results();
        end else begin
            chk("id", 4'(id), 4'(irq_id_o));
            chk("pri", 4'(p), 4'(irq_pri_o));
        end
    endtask : offer

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
            seen = seen | irq_req_o;
        end
        chk("no offer", 4'h0, 4'(seen));
    endtask : quiet

    // The core's own !claim_o guard keeps it from claiming twice in a row, whatever the delay
    task automatic take(input logic [3:0] d, input logic [1:0] dep, input logic [1:0] ap);
        @(posedge clk_sys_i);
        dly  <= d;
        auto <= 1'b1;
        repeat (20) begin
            @(posedge clk_sys_i);
            #1;
            if (depth_o === dep) break;
        end
        @(posedge clk_sys_i);
        auto <= 1'b0;
        #1;
        chk("depth", 4'(dep), 4'(depth_o));
        chk("active", 4'(ap), 4'(active_pri_o));
    endtask : take

    task automatic finish_top(input logic [1:0] dep, input logic [1:0] ap);
        @(posedge clk_sys_i);
        ret <= 1'b1;
        @(posedge clk_sys_i);
        ret <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("depth", 4'(dep), 4'(depth_o));
        chk("active", 4'(ap), 4'(active_pri_o));
    endtask : finish_top

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_reset();
        @(posedge clk_sys_i);
        #1;
        chk("thr", 4'h0, 4'(thr_o));
        chk("nest", 4'h1, 4'(nest_en_o));
        raise(8'h80);
        offer(3'h7, priority_normal_app);
        take(4'h1, 2'h1, 2'h1);
        finish_top(2'h0, 2'h0);
    endtask : s_reset

    task automatic s_threshold();
        set_pri(radio_interrupt_src, priority_radio_stack);
        set_pri(3'h3, priority_urgent_app);
        set_pri(3'h3, pri_none);
        set_thr(thr_flash);
        raise(8'h18);
        quiet(10);
        raise(8'h01);
        offer(radio_interrupt_src, priority_radio_stack);
        take(4'h3, 2'h1, 2'h2);
        finish_top(2'h0, 2'h0);
        set_thr(thr_reset);
        offer(3'h3, priority_normal_app);
        take(4'h1, 2'h1, 2'h1);
        quiet(10);
    endtask : s_threshold

    task automatic s_preempt();
        raise(8'h01);
        offer(3'h0, priority_radio_stack);
        take(4'h1, 2'h2, 2'h2);
        set_pri(3'h6, priority_urgent_app);
        set_pri(3'h5, priority_radio_stack);
        raise(8'h20);
        quiet(10);
        raise(8'h40);
        offer(3'h6, priority_urgent_app);
        take(4'h1, 2'h3, 2'h3);
        finish_top(2'h2, 2'h2);
        finish_top(2'h1, 2'h1);
        offer(3'h5, priority_radio_stack);
        take(4'h1, 2'h2, 2'h2);
        finish_top(2'h1, 2'h1);
        finish_top(2'h0, 2'h0);
        offer(3'h4, priority_normal_app);
        take(4'h1, 2'h1, 2'h1);
    endtask : s_preempt

    task automatic s_nest_off();
        @(posedge clk_sys_i);
        nest_we_i <= 1'b1;
        nest_en_i <= 1'b0;
        @(posedge clk_sys_i);
        nest_we_i <= 1'b0;
        raise(8'h40);
        quiet(10);
        chk("nest", 4'h0, 4'(nest_en_o));
        finish_top(2'h0, 2'h0);
        offer(3'h6, priority_urgent_app);
        take(4'h1, 2'h1, 2'h3);
        finish_top(2'h0, 2'h0);
        // A return with nothing in service must not wrap the depth count
        finish_top(2'h0, 2'h0);
    endtask : s_nest_off

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        s_reset();
        s_threshold();
        s_preempt();
        s_nest_off();
        results();
    end
endmodule : nested_priority_irq_gate_tb_top
